// [rtl/shs_pkg.sv]
package shs_pkg;
  // homing method selection values
  localparam logic [7:0]  METHOD_REV_LIMIT  = 8'h01;
  localparam logic [7:0]  METHOD_FWD_LIMIT  = 8'h02;
  localparam logic [7:0]  METHOD_HOME_SW    = 8'h03;
  // drive control word fields
  localparam int          CTRL_START_BIT    = 4;
  // drive state word fields
  localparam int          STAT_TARGET_BIT   = 10;
  localparam int          STAT_SWLIMIT_BIT  = 11;
  localparam int          STAT_DONE_LO_BIT  = 12;
  localparam int          STAT_ERROR_BIT    = 13;
  localparam int          STAT_DONE_HI_BIT  = 15;
  localparam logic [15:0] STATE_WORD_RESET  = 16'h0000;
  // default widths
  localparam int          SPEED_W           = 16;
  localparam int          POS_W             = 32;
  localparam int          TIME_W            = 16;
  // tick lengths in clock cycles; accel rate is speed units per ramp tick
  localparam logic [15:0] RAMP_TICK_CYCLES  = 16'h0028;
  localparam logic [15:0] WIN_TICK_CYCLES   = 16'h9C40;

  typedef enum logic [2:0] {
    SHS_IDLE,
    SHS_FAST,
    SHS_DECEL,
    SHS_SLOW_WAIT_EDGE,
    SHS_SLOW_WAIT_FALL,
    SHS_SLOW_WAIT_ZERO,
    SHS_DONE,
    SHS_FAIL
  } shs_state_e;
endpackage : shs_pkg

// [rtl/shs_speed_ramp.sv]
`timescale 1ns/1ps
module shs_speed_ramp #(
  parameter int SPEED_W = 16
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      tick,
  input  wire logic signed [SPEED_W:0]   target,
  input  wire logic        [SPEED_W-1:0] rate,
  output logic signed      [SPEED_W:0]   speed,
  output logic                           at_target
);
  logic signed [SPEED_W:0]   speed_r;
  logic signed [SPEED_W+1:0] diff;
  logic signed [SPEED_W+1:0] rate_s;
  logic signed [SPEED_W:0]   speed_nxt;

  assign diff      = {target[SPEED_W], target} - {speed_r[SPEED_W], speed_r};
  assign rate_s    = {2'b00, rate};
  // a zero rate would never converge, so it is treated as a step
  assign speed_nxt = (rate == '0) ? target :
                     (diff > rate_s) ? speed_r + $signed({1'b0, rate}) :
                     (diff < -rate_s) ? speed_r - $signed({1'b0, rate}) : target;
  assign speed     = speed_r;
  assign at_target = (speed_r == target);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_r <= '0;
    end else if (tick) begin
      speed_r <= speed_nxt;
    end
  end
endmodule : shs_speed_ramp

// [rtl/shs_homing_sequencer.sv]
`timescale 1ns/1ps
module shs_homing_sequencer #(
  parameter int SPEED_W = shs_pkg::SPEED_W,
  parameter int POS_W   = shs_pkg::POS_W,
  parameter int TIME_W  = shs_pkg::TIME_W
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [15:0]             drive_control_word,
  input  wire logic [7:0]              homing_method_select,
  input  wire logic [SPEED_W-1:0]      switch_search_speed,
  input  wire logic [SPEED_W-1:0]      zero_search_speed,
  input  wire logic [SPEED_W-1:0]      homing_accel_rate,
  input  wire logic [POS_W-1:0]        position_window,
  input  wire logic [TIME_W-1:0]       position_window_time,
  input  wire logic                    soft_limit_enable_cfg,
  input  wire logic signed [POS_W-1:0] actual_position,
  input  wire logic signed [POS_W-1:0] target_position,
  input  wire logic signed [POS_W-1:0] soft_limit_min,
  input  wire logic signed [POS_W-1:0] soft_limit_max,
  input  wire logic                    drive_fault,
  input  wire logic                    drive_warning,
  input  wire logic                    reverse_limit_input,
  input  wire logic                    forward_limit_input,
  input  wire logic                    home_switch_input,
  input  wire logic                    encoder_zero_pulse,
  output logic signed [SPEED_W:0]      speed_command,
  output logic                         homing_active,
  output logic                         homing_timeout_fault,
  output logic [15:0]                  homing_state_word
);
  shs_pkg::shs_state_e       state_r;
  shs_pkg::shs_state_e       state_nxt;
  logic                      start_q_r;
  logic                      sw_q_r;
  logic                      fwd_dir_r;
  logic                      fwd_dir_nxt;
  logic                      err_r;
  logic                      fault_r;
  logic                      tgt_r;
  logic [15:0]               ramp_cnt_r;
  logic [15:0]               ms_cnt_r;
  logic [TIME_W-1:0]         win_cnt_r;
  logic signed [SPEED_W:0]   target_spd;
  logic                      ramp_at;

  wire start_bit  = drive_control_word[shs_pkg::CTRL_START_BIT];
  wire start_rise = start_bit && !start_q_r;
  wire meth_ok    = (homing_method_select == shs_pkg::METHOD_REV_LIMIT) ||
                    (homing_method_select == shs_pkg::METHOD_FWD_LIMIT) ||
                    (homing_method_select == shs_pkg::METHOD_HOME_SW);
  // decel point chosen by the method value
  wire decel_sw   = (homing_method_select == shs_pkg::METHOD_REV_LIMIT) ? reverse_limit_input :
                    (homing_method_select == shs_pkg::METHOD_FWD_LIMIT) ? forward_limit_input :
                    home_switch_input;
  // method 1 searches reverse first, methods 2 and 3 forward
  wire fast_fwd   = (homing_method_select != shs_pkg::METHOD_REV_LIMIT);
  wire sw_rise    = decel_sw && !sw_q_r;
  wire sw_fall    = !decel_sw && sw_q_r;
  wire running    = (state_r != shs_pkg::SHS_IDLE) && (state_r != shs_pkg::SHS_DONE) &&
                    (state_r != shs_pkg::SHS_FAIL);
  wire ramp_tick  = (ramp_cnt_r == shs_pkg::RAMP_TICK_CYCLES - 16'h0001);
  wire ms_tick    = (ms_cnt_r == shs_pkg::WIN_TICK_CYCLES - 16'h0001);
  wire event_bad  = drive_fault || drive_warning;

  function automatic logic signed [SPEED_W:0] sdir(input logic [SPEED_W-1:0] s,
                                                   input logic fwd);
    sdir = fwd ? $signed({1'b0, s}) : -$signed({1'b0, s});
  endfunction : sdir

  function automatic logic [POS_W-1:0] absdiff(input logic signed [POS_W-1:0] a,
                                               input logic signed [POS_W-1:0] b);
    absdiff = (a > b) ? POS_W'(a - b) : POS_W'(b - a);
  endfunction : absdiff

  always_comb begin
    state_nxt   = state_r;
    fwd_dir_nxt = fwd_dir_r;
    case (state_r)
      shs_pkg::SHS_IDLE, shs_pkg::SHS_DONE, shs_pkg::SHS_FAIL: begin
        if (start_rise && meth_ok) begin
          if (decel_sw) begin
            // already on the switch: leave it slowly, away from it
            fwd_dir_nxt = !fast_fwd;
            state_nxt   = shs_pkg::SHS_SLOW_WAIT_FALL;
          end else begin
            fwd_dir_nxt = fast_fwd;
            state_nxt   = shs_pkg::SHS_FAST;
          end
        end
      end
      shs_pkg::SHS_FAST: begin
        if (sw_rise) begin
          fwd_dir_nxt = !fwd_dir_r;
          state_nxt   = shs_pkg::SHS_DECEL;
        end
      end
      shs_pkg::SHS_DECEL: begin
        if (ramp_at) begin
          state_nxt = shs_pkg::SHS_SLOW_WAIT_FALL;
        end
      end
      shs_pkg::SHS_SLOW_WAIT_FALL: begin
        if (sw_fall) begin
          state_nxt = shs_pkg::SHS_SLOW_WAIT_ZERO;
        end
      end
      shs_pkg::SHS_SLOW_WAIT_ZERO: begin
        if (encoder_zero_pulse) begin
          state_nxt = shs_pkg::SHS_DONE;
        end
      end
      default: begin
        state_nxt = shs_pkg::SHS_IDLE;
      end
    endcase
    if (running && !start_bit) begin
      state_nxt = shs_pkg::SHS_IDLE;
    end else if (running && event_bad) begin
      state_nxt = shs_pkg::SHS_FAIL;
    end
  end

  // fast phase uses switch search speed, decel targets zero, both slow phases the zero search speed
  assign target_spd = (state_r == shs_pkg::SHS_FAST) ? sdir(switch_search_speed, fwd_dir_r) :
                      (state_r == shs_pkg::SHS_DECEL) ? '0 :
                      (state_r == shs_pkg::SHS_SLOW_WAIT_FALL ||
                       state_r == shs_pkg::SHS_SLOW_WAIT_ZERO) ?
                      sdir(zero_search_speed, fwd_dir_r) : '0;

  shs_speed_ramp #(
    .SPEED_W (SPEED_W)
  ) u_ramp (
    .clk       (clk),
    .rst_n     (rst_n),
    .tick      (ramp_tick),
    .target    (target_spd),
    .rate      (homing_accel_rate),
    .speed     (speed_command),
    .at_target (ramp_at)
  );

  wire in_window = absdiff(actual_position, target_position) <= position_window;
  wire sw_limit  = soft_limit_enable_cfg &&
                   ((actual_position >= soft_limit_max) ||
                    (actual_position <= soft_limit_min));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= shs_pkg::SHS_IDLE;
      start_q_r  <= 1'b0;
      sw_q_r     <= 1'b0;
      fwd_dir_r  <= 1'b0;
      ramp_cnt_r <= '0;
    end else begin
      state_r    <= state_nxt;
      start_q_r  <= start_bit;
      sw_q_r     <= decel_sw;
      fwd_dir_r  <= fwd_dir_nxt;
      ramp_cnt_r <= ramp_tick ? '0 : ramp_cnt_r + 16'h0001;
    end
  end

  // error sticks until the next homing start; a fault only sets it while running, so the start cycle clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_r   <= 1'b0;
      fault_r <= 1'b0;
    end else if (running && event_bad) begin
      err_r   <= 1'b1;
      fault_r <= 1'b1;
    end else if (start_rise) begin
      err_r   <= 1'b0;
      fault_r <= 1'b0;
    end
  end

  // window time counted in milliseconds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r  <= '0;
      win_cnt_r <= '0;
      tgt_r     <= 1'b0;
    end else if (!in_window) begin
      ms_cnt_r  <= '0;
      win_cnt_r <= '0;
      tgt_r     <= 1'b0;
    end else begin
      ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 16'h0001;
      if (win_cnt_r >= position_window_time) begin
        tgt_r <= 1'b1;
      end else if (ms_tick) begin
        win_cnt_r <= win_cnt_r + {{(TIME_W-1){1'b0}}, 1'b1};
      end
    end
  end

  wire done = (state_r == shs_pkg::SHS_DONE);

  always_comb begin
    homing_state_word                            = shs_pkg::STATE_WORD_RESET;
    homing_state_word[shs_pkg::STAT_TARGET_BIT]  = tgt_r;
    homing_state_word[shs_pkg::STAT_SWLIMIT_BIT] = sw_limit;
    homing_state_word[shs_pkg::STAT_DONE_LO_BIT] = done;
    homing_state_word[shs_pkg::STAT_ERROR_BIT]   = err_r;
    homing_state_word[shs_pkg::STAT_DONE_HI_BIT] = done;
  end

  assign homing_active        = running;
  assign homing_timeout_fault = fault_r;
endmodule : shs_homing_sequencer

// [verif/shs_homing_sequencer_asserts.sv]
`timescale 1ns/1ps
module shs_homing_sequencer_asserts #(
  parameter int SPEED_W = 16,
  parameter int POS_W   = 32
) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic [15:0]             drive_control_word,
  input wire logic [7:0]              homing_method_select,
  input wire logic [SPEED_W-1:0]      homing_accel_rate,
  input wire logic                    soft_limit_enable_cfg,
  input wire logic signed [POS_W-1:0] actual_position,
  input wire logic signed [POS_W-1:0] soft_limit_max,
  input wire logic                    drive_fault,
  input wire logic                    drive_warning,
  input wire logic signed [SPEED_W:0] speed_command,
  input wire logic                    homing_active,
  input wire logic                    homing_timeout_fault,
  input wire logic [15:0]             homing_state_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ok_m;
  assign ok_m = homing_method_select inside {8'h01, 8'h02, 8'h03};
  start_go_a: assert property ($rose(drive_control_word[4]) && ok_m && !homing_active
    |=> homing_active) else $error("start missed");
  abort_stop_a: assert property (homing_active && !drive_control_word[4] && !drive_fault
    && !drive_warning |=> !homing_active && !homing_state_word[13]) else $error("abort missed");
  fault_flag_a: assert property (homing_active && drive_control_word[4] && drive_fault
    |=> homing_state_word[13] && homing_timeout_fault) else $error("fault missed");
  fault_hold_a: assert property (homing_timeout_fault && !$rose(drive_control_word[4])
    |=> homing_timeout_fault) else $error("fault dropped");
  done_low_a: assert property (homing_active |-> homing_state_word[15:12] == 4'h0)
    else $error("done while running");
  done_pair_a: assert property (homing_state_word[12] == homing_state_word[15])
    else $error("done bits differ");
  soft_lim_a: assert property (soft_limit_enable_cfg && actual_position >= soft_limit_max
    |-> homing_state_word[11]) else $error("soft limit missed");
  ramp_step_a: assert property (homing_active && $past(homing_active) |-> homing_accel_rate >=
    (speed_command >= $past(speed_command) ? speed_command - $past(speed_command)
    : $past(speed_command) - speed_command)) else $error("speed step too big");
  cover property ($rose(homing_state_word[12]));
  cover property ($rose(homing_timeout_fault));
  cover property ($rose(homing_state_word[10]));
endmodule : shs_homing_sequencer_asserts
bind shs_homing_sequencer shs_homing_sequencer_asserts #(.SPEED_W(SPEED_W), .POS_W(POS_W))
  i_shs_homing_sequencer_asserts (.clk(clk), .rst_n(rst_n),
  .drive_control_word(drive_control_word), .homing_method_select(homing_method_select),
  .homing_accel_rate(homing_accel_rate), .soft_limit_enable_cfg(soft_limit_enable_cfg),
  .actual_position(actual_position), .soft_limit_max(soft_limit_max), .drive_fault(drive_fault),
  .drive_warning(drive_warning), .speed_command(speed_command), .homing_active(homing_active),
  .homing_timeout_fault(homing_timeout_fault), .homing_state_word(homing_state_word));

// [verif/shs_motor_model.sv]
`timescale 1ns/1ps
module shs_motor_model (
  input  wire logic               clk,
  input  wire logic               load,
  input  wire logic signed [31:0] load_pos,
  input  wire logic signed [16:0] speed_command,
  output logic signed [31:0]      pos,
  output logic                    reverse_limit_input,
  output logic                    forward_limit_input,
  output logic                    home_switch_input,
  output logic                    encoder_zero_pulse
);
  logic signed [31:0] pos_q;
  // one speed unit per cycle; zero pulse on every 64-unit crossing
  always_ff @(posedge clk) begin
    pos_q <= pos;
    pos   <= load ? load_pos : pos + 32'(speed_command);
  end
  assign reverse_limit_input = pos <= -32'sh3E8;
  assign forward_limit_input = pos >= 32'sh3E8;
  assign home_switch_input   = pos >= 32'sh258 && pos <= 32'shBB8;
  assign encoder_zero_pulse  = pos[6] != pos_q[6];
endmodule : shs_motor_model

// [verif/shs_homing_sequencer_tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t %h %h", $time, (a), (e)); end end
module shs_homing_sequencer_tb;
  logic               clk = 1'b0, rst_n = 1'b0, ld = 1'b1, cfg = 1'b0;
  logic [1:0]         fw = 2'h0;
  logic [7:0]         mth = 8'h01;
  logic [15:0]        ctl = 16'h0000, sw;
  logic [31:0]        win = 32'h0;
  logic signed [31:0] p0 = 32'sh0, pos, tgt = 32'sh10000, smax = 32'sh7FFF0000;
  logic signed [16:0] spd;
  logic               act, tof, rl, fl, hs, zp;
  int                 n_mismatch = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  shs_homing_sequencer i_shs_homing_sequencer (.clk(clk), .rst_n(rst_n), .drive_control_word(ctl),
    .homing_method_select(mth), .switch_search_speed(16'h0008), .zero_search_speed(16'h0002),
    .homing_accel_rate(16'h0002), .position_window(win), .position_window_time(16'h0001),
    .soft_limit_enable_cfg(cfg), .actual_position(pos), .target_position(tgt),
    .soft_limit_min(32'h80000000), .soft_limit_max(smax), .drive_fault(fw[0]),
    .drive_warning(fw[1]), .reverse_limit_input(rl), .forward_limit_input(fl),
    .home_switch_input(hs), .encoder_zero_pulse(zp), .speed_command(spd), .homing_active(act),
    .homing_timeout_fault(tof), .homing_state_word(sw));
  shs_motor_model i_shs_motor_model (.clk(clk), .load(ld), .load_pos(p0), .speed_command(spd),
    .pos(pos), .reverse_limit_input(rl), .forward_limit_input(fl), .home_switch_input(hs),
    .encoder_zero_pulse(zp));
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick
  task automatic go(input logic [7:0] m, input int p);
    mth = m;
    p0  = p;
    ld  = 1'b1;
    tick(1);
    ld  = 1'b0;
    ctl = 16'h0010;
    tick(1);
  endtask : go
  task automatic home_run(input logic [7:0] m, input int p, d0, b, d, vmax);
    int n, v;
    v = 0;
    go(m, p);
    for (n = 0; n < 20000 && sw[12] !== 1'b1; n++) begin
      if (n == 100) `CHK(d0 * int'(spd) > 0, 1'b1)
      if (d0 * int'(spd) > v) v = d0 * int'(spd);
      tick(1);
    end
    `CHK({sw[15:12], act}, 5'h12)
    `CHK(d * (pos - b) inside {[0:80]}, 1'b1)
    `CHK(v, vmax)
    ctl = 16'h0000;
    tick(100);
  endtask : home_run
  task automatic faults;
    int i;
    go(8'h04, 0);
    `CHK(act, 1'b0)
    ctl = 16'h0000;
    tick(2);
    go(8'h01, 0);
    tick(60);
    ctl = 16'h0000;
    tick(2);
    `CHK({act, sw[13], tof}, 3'h0)
    for (i = 0; i < 2; i++) begin
      tick(100);
      go(8'h02, 0);
      tick(60);
      fw = 2'(i + 1);
      tick(2);
      `CHK({act, sw[13], tof}, 3'h3)
      fw  = 2'h0;
      ctl = 16'h0000;
    end
    tick(100);
  endtask : faults
  task automatic limits;
    p0   = 32'sh1F4;
    ld   = 1'b1;
    cfg  = 1'b1;
    smax = 32'sh1F4;
    tick(2);
    `CHK(sw[11], 1'b1)
    cfg  = 1'b0;
    tick(1);
    `CHK(sw[11], 1'b0)
    win = 32'h5;
    tgt = 32'sh1F8;
    tick(39000);
    `CHK(sw[10], 1'b0)
    tick(2000);
    `CHK(sw[10], 1'b1)
    tgt = 32'sh1FA;
    tick(2);
    `CHK(sw[10], 1'b0)
  endtask : limits
  task automatic stop_test;
    $display("errors %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    tick(4);
    rst_n = 1'b1;
    tick(2);
    faults();
    home_run(8'h01, 0, -1, -1000, 1, 8);
    home_run(8'h01, -1100, 1, -1000, 1, 2);
    home_run(8'h02, 0, 1, 1000, -1, 8);
    home_run(8'h02, 1100, -1, 1000, -1, 2);
    home_run(8'h03, 0, 1, 600, -1, 8);
    home_run(8'h03, 700, -1, 600, -1, 2);
    limits();
    stop_test();
  end
  initial begin
    #2500000;
    n_mismatch++;
    stop_test();
  end
endmodule : shs_homing_sequencer_tb
